// ===== cfi_query_host.sv
// host controller that enters, reads and leaves flash query mode
// Operation
// - write 98h to word 55h enters query
// - word reads drive A7 and above zero
// - reset command returns to array reads
// - reset from autoselect-entered query returns autoselect
`timescale 1ns/10ps
module cfi_query_host (
	input  wire logic                             ref_clk,
	input  wire logic                             reset_n,
	input  wire logic                             byte_mode,
	input  wire logic                             from_autoselect,
	input  wire logic                             cmd_valid,
	output logic                                  cmd_ready,
	input  wire logic [1:0]                       cmd_op,
	input  wire logic [cfi_host_pkg::INDEX_W-1:0] cmd_index,
	output logic                                  rsp_valid,
	output logic [cfi_host_pkg::DATA_W-1:0]       rsp_data,
	output logic                                  rsp_mismatch,
	output logic                                  query_active,
	output logic                                  autoselect_active,
	output logic [cfi_host_pkg::ADDR_W-1:0]       flash_addr,
	input  wire logic [cfi_host_pkg::DATA_W-1:0]  flash_dq_in,
	output logic [cfi_host_pkg::DATA_W-1:0]       flash_dq_out,
	output logic                                  flash_dq_oe,
	output logic                                  flash_dq15_oe,
	output logic                                  flash_ce_n,
	output logic                                  flash_oe_n,
	output logic                                  flash_we_n,
	output logic                                  flash_byte_n
);
	import cfi_host_pkg::*;

	// expected low byte for a table word; outside the table nothing is
	// checked, so the caller gates the compare with in_table()
	function automatic logic [7:0] expect_byte(
		input logic [INDEX_W-1:0] idx);
		logic [INDEX_W-1:0] off;
		off = idx - TABLE_FIRST;
		expect_byte = 8'h00;
		for (int i = 0; i < TABLE_LEN; i++) begin
			if (off == i[INDEX_W-1:0]) begin
				expect_byte = QUERY_TABLE[i];
			end
		end
	endfunction : expect_byte

	function automatic logic in_table(input logic [INDEX_W-1:0] idx);
		in_table = (idx >= TABLE_FIRST) && (idx <= TABLE_LAST);
	endfunction : in_table

	bus_state_t              state_ff, nxt_state;
	dev_mode_t               mode_ff, nxt_mode;
	logic [CNT_W-1:0]        cnt_ff, nxt_cnt;
	logic [1:0]              op_ff, nxt_op;
	logic [INDEX_W-1:0]      idx_ff, nxt_idx;
	logic [ADDR_W-1:0]       addr_ff, nxt_addr;
	logic [DATA_W-1:0]       dout_ff, nxt_dout;
	logic                    dq_oe_ff, nxt_dq_oe;
	logic                    ce_n_ff, nxt_ce_n;
	logic                    oe_n_ff, nxt_oe_n;
	logic                    we_n_ff, nxt_we_n;
	logic                    byte_n_ff, nxt_byte_n;
	logic                    rsp_valid_ff, nxt_rsp_valid;
	logic [DATA_W-1:0]       rsp_data_ff, nxt_rsp_data;
	logic                    mism_ff, nxt_mism;
	logic [DATA_W-1:0]       dq_s1_ff, dq_s2_ff;
	logic [DATA_W-1:0]       rd_word;
	logic                    accept;

	// new work only while the bus is quiet; a read outside query mode
	// is still allowed so software can fetch array data too
	assign cmd_ready = (state_ff == ST_IDLE);
	assign accept    = cmd_valid && cmd_ready;

	// in byte mode only the low lane carries table data
	assign rd_word = byte_mode ? {8'h00, dq_s2_ff[7:0]} : dq_s2_ff;

	// bus sequencer and mode tracking, next values
	always_comb begin
		nxt_state     = state_ff;
		nxt_mode      = mode_ff;
		nxt_cnt       = cnt_ff;
		nxt_op        = op_ff;
		nxt_idx       = idx_ff;
		nxt_addr      = addr_ff;
		nxt_dout      = dout_ff;
		nxt_dq_oe     = dq_oe_ff;
		nxt_ce_n      = ce_n_ff;
		nxt_oe_n      = oe_n_ff;
		nxt_we_n      = we_n_ff;
		nxt_byte_n    = ~byte_mode;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data  = rsp_data_ff;
		nxt_mism      = mism_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept) begin
					nxt_op   = cmd_op;
					nxt_idx  = cmd_index;
					nxt_ce_n = 1'b0;
					// index is 7 bits wide, so A7 and up stay zero;
					// in byte mode A-1 is held low, which doubles it
					nxt_addr = {{(ADDR_W-INDEX_W){1'b0}}, cmd_index};
					if (cmd_op == OP_READ) begin
						nxt_oe_n  = 1'b0;
						nxt_dq_oe = 1'b0;
						nxt_cnt   = CNT_W'(READ_CYC + SYNC_CYC);
						nxt_state = ST_READ;
					end else begin
						nxt_dq_oe = 1'b1;
						if (cmd_op == OP_ENTER) begin
							nxt_addr = {{(ADDR_W-INDEX_W){1'b0}},
								QUERY_ADDR};
							nxt_dout = {8'h00, CMD_QUERY};
						end else begin
							nxt_dout = {8'h00, CMD_RESET};
						end
						nxt_state = ST_SETUP;
					end
				end
			end
			ST_SETUP: begin
				// address and data settle before the write strobe falls
				nxt_we_n  = 1'b0;
				nxt_cnt   = CNT_W'(WE_CYC);
				nxt_state = ST_STROBE;
			end
			ST_STROBE: begin
				if (cnt_ff <= CNT_W'(1)) begin
					nxt_we_n  = 1'b1;
					nxt_state = ST_RECOV;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			ST_RECOV: begin
				// data held one cycle past the rising strobe
				nxt_ce_n  = 1'b1;
				nxt_dq_oe = 1'b0;
				nxt_state = ST_IDLE;
				if (op_ff == OP_ENTER) begin
					// a repeated enter keeps the entry path it already has
					if (mode_ff == MD_AUTO
						|| (mode_ff == MD_ARRAY && from_autoselect)) begin
						nxt_mode = MD_QAUTO;
					end else if (mode_ff == MD_ARRAY) begin
						nxt_mode = MD_QARR;
					end
				end else if (mode_ff == MD_QAUTO) begin
					nxt_mode = MD_AUTO;
				end else begin
					nxt_mode = MD_ARRAY;
				end
			end
			ST_READ: begin
				// hold the read long enough for access time plus the
				// two sync flops, then sample the settled word
				if (cnt_ff <= CNT_W'(1)) begin
					nxt_ce_n      = 1'b1;
					nxt_oe_n      = 1'b1;
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data  = rd_word;
					// table words are checked only in query mode
					nxt_mism = (mode_ff == MD_QARR || mode_ff == MD_QAUTO)
						&& in_table(idx_ff)
						&& (rd_word != {8'h00, expect_byte(idx_ff)});
					nxt_state = ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - CNT_W'(1);
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_ce_n  = 1'b1;
				nxt_oe_n  = 1'b1;
				nxt_we_n  = 1'b1;
				nxt_dq_oe = 1'b0;
			end
		endcase
	end

	// registers for sequencer, pins and response
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff     <= ST_IDLE;
			mode_ff      <= MD_ARRAY;
			cnt_ff       <= '0;
			op_ff        <= OP_READ;
			idx_ff       <= '0;
			addr_ff      <= '0;
			dout_ff      <= '0;
			dq_oe_ff     <= 1'b0;
			ce_n_ff      <= 1'b1;
			oe_n_ff      <= 1'b1;
			we_n_ff      <= 1'b1;
			byte_n_ff    <= 1'b1;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= '0;
			mism_ff      <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			mode_ff      <= nxt_mode;
			cnt_ff       <= nxt_cnt;
			op_ff        <= nxt_op;
			idx_ff       <= nxt_idx;
			addr_ff      <= nxt_addr;
			dout_ff      <= nxt_dout;
			dq_oe_ff     <= nxt_dq_oe;
			ce_n_ff      <= nxt_ce_n;
			oe_n_ff      <= nxt_oe_n;
			we_n_ff      <= nxt_we_n;
			byte_n_ff    <= nxt_byte_n;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff  <= nxt_rsp_data;
			mism_ff      <= nxt_mism;
		end
	end

	// data pins come from an unclocked part; second flop alone is read
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
		end else begin
			dq_s1_ff <= flash_dq_in;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	// pin and status outputs
	assign flash_addr        = addr_ff;
	assign flash_dq_out      = byte_n_ff ? dout_ff : {1'b0, dout_ff[14:0]};
	assign flash_dq_oe       = dq_oe_ff;
	// in byte mode bit 15 is the lowest address bit, held low always
	assign flash_dq15_oe     = dq_oe_ff || !byte_n_ff;
	assign flash_ce_n        = ce_n_ff;
	assign flash_oe_n        = oe_n_ff;
	assign flash_we_n        = we_n_ff;
	assign flash_byte_n      = byte_n_ff;
	assign rsp_valid         = rsp_valid_ff;
	assign rsp_data          = rsp_data_ff;
	assign rsp_mismatch      = mism_ff;
	assign query_active      = (mode_ff == MD_QARR) || (mode_ff == MD_QAUTO);
	assign autoselect_active = (mode_ff == MD_AUTO);
endmodule : cfi_query_host

// ===== cfi_host_pkg.sv
// shared constants for the query-mode host controller
package cfi_host_pkg;
	// bus timing, a plain default and the clock it is counted in
	localparam int CLK_PERIOD_NS  = 100;
	localparam int READ_ACCESS_NS = 100;
	localparam int WE_PULSE_NS    = 100;
	// least times round up to whole cycles
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WE_CYC   = (WE_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// data pins pass two flops before they are sampled
	localparam int SYNC_CYC = 2;
	localparam int CNT_W    = 4;

	// pin widths
	localparam int ADDR_W  = 22;
	localparam int DATA_W  = 16;
	localparam int INDEX_W = 7;

	// command codes and the query entry address
	localparam logic [7:0]         CMD_QUERY  = 8'h98;
	localparam logic [7:0]         CMD_RESET  = 8'hF0;
	localparam logic [INDEX_W-1:0] QUERY_ADDR = 7'h55;

	// user operations
	localparam logic [1:0] OP_ENTER = 2'h0;
	localparam logic [1:0] OP_READ  = 2'h1;
	localparam logic [1:0] OP_EXIT  = 2'h2;

	// expected table, low byte of each word, from word 10h to 3Ch
	localparam logic [INDEX_W-1:0] TABLE_FIRST = 7'h10;
	localparam logic [INDEX_W-1:0] TABLE_LAST  = 7'h3C;
	localparam int TABLE_LEN = 45;
	localparam logic [7:0] QUERY_TABLE [TABLE_LEN] = '{
		8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04,
		8'h00, 8'h0A, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h17,
		8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h07, 8'h00, 8'h20,
		8'h00, 8'h7E, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};

	// bus sequencer states
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_SETUP  = 5'h02,
		ST_STROBE = 5'h04,
		ST_RECOV  = 5'h08,
		ST_READ   = 5'h10
	} bus_state_t;

	// where the device stands, as far as the host knows
	typedef enum logic [3:0] {
		MD_ARRAY = 4'h1,
		MD_AUTO  = 4'h2,
		MD_QARR  = 4'h4,
		MD_QAUTO = 4'h8
	} dev_mode_t;
endpackage : cfi_host_pkg

// ===== cfi_query_host_monitor.sv
// pin-level checks on the query-mode host controller
`timescale 1ns/10ps
module cfi_query_host_monitor (
	input wire logic                             ref_clk,
	input wire logic                             reset_n,
	input wire logic                             cmd_valid,
	input wire logic                             cmd_ready,
	input wire logic [1:0]                       cmd_op,
	input wire logic [cfi_host_pkg::INDEX_W-1:0] cmd_index,
	input wire logic                             rsp_valid,
	input wire logic                             query_active,
	input wire logic                             autoselect_active,
	input wire logic [cfi_host_pkg::ADDR_W-1:0]  flash_addr,
	input wire logic [cfi_host_pkg::DATA_W-1:0]  flash_dq_out,
	input wire logic                             flash_dq_oe,
	input wire logic                             flash_dq15_oe,
	input wire logic                             flash_ce_n,
	input wire logic                             flash_oe_n,
	input wire logic                             flash_we_n,
	input wire logic                             flash_byte_n
);
	import cfi_host_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// accepted requests; op 3 counts as exit
	sequence take_enter; cmd_valid && cmd_ready && cmd_op == OP_ENTER; endsequence
	sequence take_read; cmd_valid && cmd_ready && cmd_op == OP_READ; endsequence
	sequence take_exit; cmd_valid && cmd_ready && cmd_op[1]; endsequence
	AST_HIGH_ADDR: assert property (!flash_ce_n |-> flash_addr[21:7] == '0)
		else $error("upper address bits set");
	AST_ENTER_CMD: assert property (take_enter |=> flash_dq_oe &&
		flash_addr[6:0] == QUERY_ADDR && flash_dq_out[7:0] == CMD_QUERY)
		else $error("query command not driven");
	AST_ENTER_MODE: assert property (take_enter |-> ##4 query_active)
		else $error("query mode not entered");
	AST_EXIT_CMD: assert property (take_exit |=> flash_dq_oe &&
		flash_dq_out[7:0] == CMD_RESET)
		else $error("reset command not driven");
	AST_EXIT_MODE: assert property (take_exit |-> ##4 !query_active)
		else $error("query mode not left");
	AST_AUTO_BACK: assert property ($rose(autoselect_active) |-> $fell(query_active))
		else $error("autoselect without leaving query");
	AST_WE_PULSE: assert property ($fell(flash_we_n) |->
		!flash_ce_n && flash_oe_n ##1 $rose(flash_we_n))
		else $error("bad write strobe");
	AST_READ_RSP: assert property (take_read |-> ##4 rsp_valid)
		else $error("read answer late");
	AST_READ_ADDR: assert property (take_read |=> !flash_oe_n &&
		!flash_dq_oe && flash_addr[6:0] == $past(cmd_index))
		else $error("read address wrong");
	AST_BYTE_A1: assert property (!flash_byte_n && !flash_ce_n |->
		flash_dq15_oe && !flash_dq_out[15])
		else $error("low address bit not driven low");
endmodule : cfi_query_host_monitor
bind cfi_query_host cfi_query_host_monitor mon (.ref_clk, .reset_n, .cmd_valid,
	.cmd_ready, .cmd_op, .cmd_index, .rsp_valid, .query_active,
	.autoselect_active, .flash_addr, .flash_dq_out, .flash_dq_oe,
	.flash_dq15_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n);

// ===== cfi_flash_model.sv
// behavioural flash answering query, autoselect and array reads
`timescale 1ns/10ps
module cfi_flash_model (
	input wire logic [cfi_host_pkg::ADDR_W-1:0] addr,
	input wire logic [cfi_host_pkg::DATA_W-1:0] dq_w,
	input wire logic                            ce_n,
	input wire logic                            oe_n,
	input wire logic                            we_n,
	input wire logic                            byte_n,
	input wire logic                            go_auto,
	output logic     [cfi_host_pkg::DATA_W-1:0] dq_r
);
	import cfi_host_pkg::*;
	// query words 10h..3Ch, first at the top
	localparam logic [359:0] TAB = {
		192'h515259_020040_000000_000027_360000_04000A_000500_040017,
		168'h020000_000207_002000_7E0000_010000_000000_000000
	};
	logic [1:0]  mode = 2'd0; // 0 array, 1 auto, 2/3 query from those
	logic [15:0] last = 16'h0000;
	logic [15:0] drv;
	logic [7:0]  qv;
	wire  [6:0]  w = addr[6:0];
	// table only with upper address bits clear and, in byte mode, A-1 low
	assign qv = (w >= 16 && w <= 60 && addr[21:7] == '0
		&& (byte_n || !dq_w[15])) ? TAB[8*(60-w)+:8] : 8'hFF;
	always @(posedge go_auto) mode = 2'd1;
	// commands land on the rising write strobe
	always @(posedge we_n) if (!ce_n) begin
		if (dq_w[7:0] == 8'h98 && addr == 22'h55 && (byte_n || !dq_w[15])
			&& !mode[1]) mode = mode + 2'd2;
		else if (dq_w[7:0] == 8'hF0) mode = (mode == 2'd3) ? 2'd1 : 2'd0;
	end
	// word the device puts out; table words carry a zero upper byte
	always @* begin
		if (mode[1]) drv = {8'h00, qv};
		else if (mode == 2'd1) drv = 16'h00C3;
		else drv = ~addr[15:0];
	end
	// byte mode leaves the upper lane undriven, so it shows a stale level;
	// a released bus shows the inverse of the last driven word
	always @* begin
		if (!ce_n && !oe_n) dq_r = byte_n ? drv : {~last[15:8], drv[7:0]};
		else dq_r = ~last;
	end
	// taken at the end of a read, so the bus never feeds back on itself
	always @(posedge oe_n) last = drv;
endmodule : cfi_flash_model

// ===== test_cfi_query_host.sv
// self-checking bench for the query-mode host controller
`timescale 1ns/10ps
module test_cfi_query_host;
	import cfi_host_pkg::*;
	logic ref_clk = 0, reset_n = 0, byte_mode = 0, from_autoselect = 0;
	logic cmd_valid = 0, go_auto = 0;
	logic [1:0] cmd_op = 0;
	logic [INDEX_W-1:0] cmd_index = 0;
	logic cmd_ready, rsp_valid, rsp_mismatch, query_active, autoselect_active;
	logic [DATA_W-1:0] rsp_data, flash_dq_out, dq_r, flash_dq_in;
	logic [ADDR_W-1:0] flash_addr;
	logic flash_dq_oe, flash_dq15_oe, flash_ce_n, flash_oe_n, flash_we_n;
	logic flash_byte_n;
	int n_errors = 0, n_compared = 0, cycles = 0;
	always #50 ref_clk = ~ref_clk;
	// wire level from the host's two enables; the flash always drives the rest
	assign flash_dq_in = {flash_dq15_oe ? flash_dq_out[15] : dq_r[15],
		flash_dq_oe ? flash_dq_out[14:0] : dq_r[14:0]};
	cfi_query_host uut (.ref_clk, .reset_n, .byte_mode, .from_autoselect,
		.cmd_valid, .cmd_ready, .cmd_op, .cmd_index, .rsp_valid, .rsp_data,
		.rsp_mismatch, .query_active, .autoselect_active, .flash_addr,
		.flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_dq15_oe,
		.flash_ce_n, .flash_oe_n, .flash_we_n, .flash_byte_n);
	cfi_flash_model far (.addr(flash_addr), .dq_w(flash_dq_in),
		.ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
		.byte_n(flash_byte_n), .go_auto(go_auto), .dq_r(dq_r));
	task automatic stop_test;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// one request, held until taken, then wait for idle
	task automatic issue(input logic [1:0] op, input logic [6:0] idx);
		@(negedge ref_clk);
		while (cmd_ready !== 1'b1) @(negedge ref_clk);
		cmd_op = op;
		cmd_index = idx;
		cmd_valid = 1;
		@(negedge ref_clk);
		cmd_valid = 0;
		for (int k = 0; k < 8 && cmd_ready !== 1'b1; k++) @(negedge ref_clk);
	endtask : issue
	// enter, walk the whole table, leave, in the current addressing mode
	task automatic walk_table;
		issue(OP_ENTER, 7'h00);
		check(query_active, 1'b1);
		for (int i = 16; i <= 60; i++) begin
			issue(OP_READ, i[6:0]);
			check(rsp_data, {8'h00, far.TAB[8*(60-i)+:8]});
			check(rsp_mismatch, 1'b0);
		end
		issue(OP_EXIT, 7'h00);
		check(query_active, 1'b0);
		issue(OP_READ, 7'h10);
		check(rsp_data, byte_mode ? 16'h00EF : 16'hFFEF);
	endtask : walk_table
	task automatic byte_query;
		byte_mode = 1;
		repeat (3) @(negedge ref_clk);
		walk_table();
		byte_mode = 0;
		repeat (3) @(negedge ref_clk);
	endtask : byte_query
	// entry from autoselect and return to it
	task automatic auto_query;
		go_auto = 1;
		from_autoselect = 1;
		issue(OP_ENTER, 7'h00);
		check(query_active, 1'b1);
		issue(OP_READ, 7'h1B);
		check(rsp_data, 16'h0027);
		issue(OP_EXIT, 7'h00);
		check(autoselect_active, 1'b1);
		issue(OP_READ, 7'h10);
		check(rsp_data, 16'h00C3);
		// second entry relies on the autoselect mode the host now tracks
		from_autoselect = 0;
		issue(OP_ENTER, 7'h00);
		check(query_active, 1'b1);
		issue(OP_EXIT, 7'h00);
		check(autoselect_active, 1'b1);
	endtask : auto_query
	// hang guard, well above the roughly 540 cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		reset_n = 1;
		walk_table();
		byte_query();
		auto_query();
		stop_test();
	end
endmodule : test_cfi_query_host
